// file: lsl_pkg.sv
// Package for the limit switch logic input decoder
package lsl_pkg;

  // ****************************************************
  // Wishbone register map (word offsets as byte addresses)
  // ****************************************************
  localparam logic [7:0] LSL_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] LSL_ADDR_STATUS  = 8'h04;
  localparam logic [7:0] LSL_ADDR_SPEED   = 8'h08;
  localparam logic [7:0] LSL_ADDR_LOW     = 8'h0c;
  localparam logic [7:0] LSL_ADDR_HIGH    = 8'h10;
  localparam logic [7:0] LSL_ADDR_OFFSET  = 8'h14;
  localparam logic [7:0] LSL_ADDR_POS     = 8'h18;
  localparam logic [7:0] LSL_ADDR_CODE    = 8'h1c;
  localparam logic [7:0] LSL_ADDR_OUTCFG  = 8'h20;

  // ****************************************************
  // Field layout and widths
  // ****************************************************
  localparam int          LSL_POS_W      = 16;
  localparam int          LSL_NOUT       = 16;
  localparam logic [2:0]  LSL_PROG_ONE   = 3'h0;   // Program 1 encoded as zero
  localparam logic [15:0] LSL_CODE_RST   = 16'h1234; // Arbitrary default enable code
  localparam logic [3:0]  LSL_DEB_CYCLES = 4'ha;   // Stable samples before accept
  localparam logic [31:0] LSL_UNMAPPED   = 32'h0;

  // ****************************************************
  // Types
  // ****************************************************
  // Raw or filtered logic inputs, active high after inversion
  typedef struct packed {
    logic       oper_en;
    logic       master_en;
    logic       rezero;
    logic [2:0] sel;          // sel[0]=a, sel[1]=b, sel[2]=c
  } lsl_inputs_t;

  typedef enum logic [1:0] {
    LSL_GRP_ALWAYS  = 2'h0,
    LSL_GRP_LEVEL   = 2'h1,
    LSL_GRP_LATCH   = 2'h2,
    LSL_GRP_ONESHOT = 2'h3
  } lsl_grp_mode_t;

  // Wishbone bus states
  typedef enum logic [1:0] {
    LSL_BUS_IDLE = 2'b01,
    LSL_BUS_ACK  = 2'b10
  } lsl_bus_state_t;

endpackage : lsl_pkg

// file: lsl_logic_inputs.sv
// Logic input decoder, re-zero, access control and motion status
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Inputs are active low, pulled to common
// - Three select lines map to eight programs
// - Any asserted select overrides keypad program
// - Master enable grants all programming access
// - Re-zero on leading edge only, not held
// - After restart, position clears to zero; programmed offset is not loaded
// - Grouped models: input enables group one, except in LSL_GRP_ALWAYS mode (the reset default), where it is always on
// - Motion flag while low <= speed <= high
// - Any output may follow motion condition
// - Operator enable grants operator-level access
// - Valid keypad code also grants operator access
module lsl_logic_inputs
  import lsl_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [2:0]          sel_n_i,
  input  wire logic                master_en_n_i,
  input  wire logic                oper_en_n_i,
  input  wire logic                rezero_n_i,
  input  wire logic                grouped_model_i,
  input  wire logic                pos_step_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic                wb_we_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     motion_o,
  output logic      [2:0]          program_number_o,
  output logic                     master_access_o,
  output logic                     oper_access_o,
  output logic                     group1_enable_o,
  output logic      [LSL_POS_W-1:0] position_o,
  output logic      [LSL_NOUT-1:0] motion_outputs_o
);

  // ****************************************************
  // Functions
  // ****************************************************
  // Select lines (a,b,c) to zero-based program index
  function automatic logic [2:0] sel_to_prog(input logic [2:0] s);
    logic [2:0] p;
    p = LSL_PROG_ONE;
    case (s)
      3'h0: p = 3'h0;
      3'h1: p = 3'h1;
      3'h3: p = 3'h2;
      3'h2: p = 3'h3;
      3'h6: p = 3'h4;
      3'h7: p = 3'h5;
      3'h5: p = 3'h6;
      3'h4: p = 3'h7;
      default: p = LSL_PROG_ONE;
    endcase
    return p;
  endfunction : sel_to_prog

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ****************************************************
  // Synchroniser and debounce
  // ****************************************************
  lsl_inputs_t sync1;
  lsl_inputs_t sync2;
  lsl_inputs_t filt;
  lsl_inputs_t next_filt;
  lsl_inputs_t raw;
  logic [3:0]  deb_cnt [6];
  logic [3:0]  next_deb_cnt [6];

  // Invert active-low pins into active-high view
  assign raw = '{oper_en: ~oper_en_n_i, master_en: ~master_en_n_i,
                 rezero: ~rezero_n_i, sel: ~sel_n_i};

  // Per-bit counter: accept a level once it holds steady
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 6; i++) begin
      next_deb_cnt[i] = 4'h0;
      if (sync2[i] != filt[i]) begin
        next_deb_cnt[i] = deb_cnt[i] + 4'h1;
        if (deb_cnt[i] == LSL_DEB_CYCLES - 4'h1) begin
          next_filt[i]    = sync2[i];
          next_deb_cnt[i] = 4'h0;
        end
      end
    end
  end

  // Two-stage sync then filtered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      filt  <= '0;
      for (int i = 0; i < 6; i++) begin
        deb_cnt[i] <= 4'h0;
      end
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      filt  <= next_filt;
      deb_cnt <= next_deb_cnt;
    end
  end

  // ****************************************************
  // Registers and Wishbone slave
  // ****************************************************
  lsl_bus_state_t      bus_st;
  lsl_bus_state_t      next_bus_st;
  logic [2:0]          keypad_active_program;
  logic [2:0]          next_keypad_active_program;
  logic [15:0]         speed;
  logic [15:0]         next_speed;
  logic [15:0]         speed_low;
  logic [15:0]         next_speed_low;
  logic [15:0]         speed_high;
  logic [15:0]         next_speed_high;
  logic [LSL_POS_W-1:0] position_offset_setting;
  logic [LSL_POS_W-1:0] next_position_offset_setting;
  logic [15:0]         enable_code;
  logic [15:0]         next_enable_code;
  logic                code_ok;
  logic                next_code_ok;
  logic [1:0]          grp_mode;
  logic [1:0]          next_grp_mode;
  logic [LSL_NOUT-1:0] out_cfg;
  logic [LSL_NOUT-1:0] next_out_cfg;
  logic [31:0]         next_dat;
  logic [31:0]         wr;
  logic                wr_en;
  logic                rezero_prev;
  logic                rezero_rise;
  logic                motion_in_range;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && (bus_st == LSL_BUS_IDLE);

  // Bus and register next values
  always_comb begin
    next_bus_st                  = bus_st;
    next_keypad_active_program   = keypad_active_program;
    next_speed                   = speed;
    next_speed_low               = speed_low;
    next_speed_high              = speed_high;
    next_position_offset_setting = position_offset_setting;
    next_enable_code             = enable_code;
    next_code_ok                 = code_ok;
    next_grp_mode                = grp_mode;
    next_out_cfg                 = out_cfg;
    next_dat                     = wb_dat_o;
    wr                           = 32'h0;
    case (bus_st)
      LSL_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          next_bus_st = LSL_BUS_ACK;
          next_dat    = LSL_UNMAPPED;
          if (wb_adr_i == LSL_ADDR_CTRL) begin
            wr = merge({27'h0, grp_mode, keypad_active_program}, wb_dat_i, wb_sel_i);
            next_dat = {27'h0, grp_mode, keypad_active_program};
            if (wr_en) begin
              next_keypad_active_program = wr[2:0];
              next_grp_mode              = wr[4:3];
            end
          end else if (wb_adr_i == LSL_ADDR_STATUS) begin
            next_dat = {21'h0, code_ok, filt, motion_o, program_number_o};
          end else if (wb_adr_i == LSL_ADDR_SPEED) begin
            wr = merge({16'h0, speed}, wb_dat_i, wb_sel_i);
            next_dat = {16'h0, speed};
            if (wr_en) next_speed = wr[15:0];
          end else if (wb_adr_i == LSL_ADDR_LOW) begin
            wr = merge({16'h0, speed_low}, wb_dat_i, wb_sel_i);
            next_dat = {16'h0, speed_low};
            if (wr_en) next_speed_low = wr[15:0];
          end else if (wb_adr_i == LSL_ADDR_HIGH) begin
            wr = merge({16'h0, speed_high}, wb_dat_i, wb_sel_i);
            next_dat = {16'h0, speed_high};
            if (wr_en) next_speed_high = wr[15:0];
          end else if (wb_adr_i == LSL_ADDR_OFFSET) begin
            wr = merge({16'h0, position_offset_setting}, wb_dat_i, wb_sel_i);
            next_dat = {16'h0, position_offset_setting};
            if (wr_en) next_position_offset_setting = wr[15:0];
          end else if (wb_adr_i == LSL_ADDR_POS) begin
            next_dat = {16'h0, position_o};
          end else if (wb_adr_i == LSL_ADDR_CODE) begin
            // Write a guess; match unlocks operator level
            if (wr_en) next_code_ok = (wb_dat_i[15:0] == enable_code);
            next_dat = {31'h0, code_ok};
          end else if (wb_adr_i == LSL_ADDR_OUTCFG) begin
            wr = merge({16'h0, out_cfg}, wb_dat_i, wb_sel_i);
            next_dat = {16'h0, out_cfg};
            if (wr_en) next_out_cfg = wr[15:0];
          end
        end
      end
      LSL_BUS_ACK: begin
        next_bus_st = LSL_BUS_IDLE;
      end
      default: next_bus_st = LSL_BUS_IDLE;
    endcase
  end

  // ****************************************************
  // Decode of inputs
  // ****************************************************
  assign rezero_rise     = filt.rezero && !rezero_prev;
  assign motion_in_range = (speed >= speed_low) && (speed <= speed_high);

  // Register all state and outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st                  <= LSL_BUS_IDLE;
      wb_ack_o                <= 1'b0;
      wb_dat_o                <= 32'h0;
      keypad_active_program   <= LSL_PROG_ONE;
      speed                   <= 16'h0;
      speed_low               <= 16'h0;
      speed_high              <= 16'h0;
      position_offset_setting <= '0;
      enable_code             <= LSL_CODE_RST;
      code_ok                 <= 1'b0;
      grp_mode                <= LSL_GRP_ALWAYS;
      out_cfg                 <= '0;
      rezero_prev             <= 1'b0;
      position_o              <= '0;
      motion_o                <= 1'b0;
      program_number_o        <= LSL_PROG_ONE;
      master_access_o         <= 1'b0;
      oper_access_o           <= 1'b0;
      group1_enable_o         <= 1'b0;
      motion_outputs_o        <= '0;
    end else begin
      bus_st                  <= next_bus_st;
      wb_ack_o                <= (next_bus_st == LSL_BUS_ACK);
      wb_dat_o                <= next_dat;
      keypad_active_program   <= next_keypad_active_program;
      speed                   <= next_speed;
      speed_low               <= next_speed_low;
      speed_high              <= next_speed_high;
      position_offset_setting <= next_position_offset_setting;
      enable_code             <= next_enable_code;
      code_ok                 <= next_code_ok;
      grp_mode                <= next_grp_mode;
      out_cfg                 <= next_out_cfg;
      rezero_prev             <= filt.rezero;
      // Position: edge re-zero wins over counting step
      if (!grouped_model_i && rezero_rise) begin
        position_o <= '0;
      end else if (pos_step_i) begin
        position_o <= position_o + 16'h1;
      end
      motion_o         <= motion_in_range;
      motion_outputs_o <= out_cfg & {LSL_NOUT{motion_in_range}};
      program_number_o <= (|filt.sel) ? sel_to_prog(filt.sel)
                                      : keypad_active_program;
      master_access_o  <= filt.master_en;
      oper_access_o    <= filt.master_en | filt.oper_en | code_ok;
      // Group one enable under programmable mode
      case (grp_mode)
        LSL_GRP_ALWAYS:  group1_enable_o <= grouped_model_i;
        LSL_GRP_LEVEL:   group1_enable_o <= grouped_model_i & filt.rezero;
        LSL_GRP_LATCH:   group1_enable_o <= grouped_model_i & (group1_enable_o | rezero_rise);
        LSL_GRP_ONESHOT: group1_enable_o <= grouped_model_i & rezero_rise;
        default:         group1_enable_o <= 1'b0;
      endcase
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  property p_motion;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> motion_o == $past(motion_in_range);
  endproperty
  a_motion: assert property (p_motion) else $error("motion flag wrong");

  property p_override;
    @(posedge clk_i) disable iff (rst_i)
      (|filt.sel) |=> program_number_o == sel_to_prog($past(filt.sel));
  endproperty
  a_override: assert property (p_override) else $error("select override failed");

  property p_keypad;
    @(posedge clk_i) disable iff (rst_i)
      (filt.sel == 3'h0) |=> program_number_o == $past(keypad_active_program);
  endproperty
  a_keypad: assert property (p_keypad) else $error("keypad program not used");

  property p_rezero;
    @(posedge clk_i) disable iff (rst_i)
      (rezero_rise && !grouped_model_i) |=> position_o == '0;
  endproperty
  a_rezero: assert property (p_rezero) else $error("re-zero missed");

  property p_noheld;
    @(posedge clk_i) disable iff (rst_i)
      (filt.rezero && rezero_prev && pos_step_i) |=> position_o != '0 || $past(position_o) == '1;
  endproperty
  a_noheld: assert property (p_noheld) else $error("position held at zero");

  property p_master;
    @(posedge clk_i) disable iff (rst_i)
      filt.master_en [*2] |-> master_access_o && oper_access_o;
  endproperty
  a_master: assert property (p_master) else $error("master access missing");

  property p_oper;
    @(posedge clk_i) disable iff (rst_i)
      $rose(filt.oper_en) |=> oper_access_o;
  endproperty
  a_oper: assert property (p_oper) else $error("operator access missing");

  property p_debounce;
    @(posedge clk_i) disable iff (rst_i)
      $changed(filt) |-> ((filt ^ $past(filt)) & (filt ^ $past(sync2))) == 6'h0;
  endproperty
  a_debounce: assert property (p_debounce) else $error("unfiltered change");

endmodule : lsl_logic_inputs
`default_nettype wire

// file: lsl_switches.sv
// Model of the switches, relays or PLC outputs on the logic inputs
`timescale 1ns/1ps
`default_nettype none
module lsl_switches (
  input  wire logic [2:0] sel_on_i,
  input  wire logic       master_on_i,
  input  wire logic       oper_on_i,
  input  wire logic       rezero_on_i,
  output logic      [2:0] sel_n_o,
  output logic            master_en_n_o,
  output logic            oper_en_n_o,
  output logic            rezero_n_o
);
  // Closed contact pulls to common, open contact sits at the pull-up
  assign sel_n_o       = ~sel_on_i;
  assign master_en_n_o = ~master_on_i;
  assign oper_en_n_o   = ~oper_on_i;
  assign rezero_n_o    = ~rezero_on_i;
endmodule : lsl_switches
`default_nettype wire

// file: tb_lsl_logic_inputs.sv
// Self-checking bench for the logic input decoder
`timescale 1ns/1ps
`default_nettype none
module tb_lsl_logic_inputs;
  import lsl_pkg::*;
  logic clk_i = 0, rst_i = 1, grouped = 0, step = 0;
  logic [2:0] sel_on = 0;
  logic master_on = 0, oper_on = 0, rezero_on = 0;
  logic [2:0] sel_n;
  logic master_n, oper_n, rezero_n;
  logic [7:0] adr = 0;
  logic [3:0] be = 0;
  logic [31:0] dat = 0, rdat, s;
  logic we = 0, cyc = 0, stb = 0, ack, motion, macc, oacc, g1, e;
  logic [2:0] prog;
  logic [15:0] pos, mout;
  logic [31:0] expq[$];
  logic [31:0] rng = 32'h3b;
  logic [2:0] tbl [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
  int failures = 0, checks_done = 0, cycles = 0;

  // Clock
  always #12.5 clk_i = ~clk_i;

  lsl_switches SW (.sel_on_i(sel_on), .master_on_i(master_on), .oper_on_i(oper_on),
    .rezero_on_i(rezero_on), .sel_n_o(sel_n), .master_en_n_o(master_n),
    .oper_en_n_o(oper_n), .rezero_n_o(rezero_n));

  lsl_logic_inputs DUT (.clk_i(clk_i), .rst_i(rst_i), .sel_n_i(sel_n),
    .master_en_n_i(master_n), .oper_en_n_i(oper_n), .rezero_n_i(rezero_n),
    .grouped_model_i(grouped), .pos_step_i(step), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(be), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .motion_o(motion), .program_number_o(prog),
    .master_access_o(macc), .oper_access_o(oacc), .group1_enable_o(g1),
    .position_o(pos), .motion_outputs_o(mout));

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs

  task automatic summarize;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; be <= m;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 0; stb <= 0; we <= 0;
    if (ack !== 1'b1) chk(32'h0, 32'h1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    expq.push_back(want);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  // Contacts change, then the filter is given time to accept
  task automatic pins(input logic [2:0] sl, input logic m, input logic o, input logic r);
    @(posedge clk_i);
    sel_on <= sl; master_on <= m; oper_on <= o; rezero_on <= r;
    tick(16);
    #1;
  endtask : pins

  task automatic stepn(input int n);
    repeat (n) begin
      @(posedge clk_i);
      step <= 1;
      @(posedge clk_i);
      step <= 0;
    end
    tick(2);
    #1;
  endtask : stepn

  // Read data taken at the ack edge, against the oldest note
  always @(posedge clk_i) if (ack === 1'b1 && cyc && !we) chk(rdat, expq.pop_front());

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize;
    end
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    tick(10);
    rst_i <= 0;
    tick(2);
    wr(LSL_ADDR_CTRL, 32'h5);
    pins(3'h0, 0, 0, 0);
    chk(prog, 32'h5);
    for (int i = 1; i < 8; i++) begin
      pins(tbl[i], 0, 0, 0);
      chk(prog, i);
    end
    pins(3'h0, 0, 0, 0);
    wr(LSL_ADDR_CTRL, 32'h0);
    tick(2);
    #1;
    chk(prog, 32'h0);
    chk({macc, oacc}, 32'h0);
    pins(3'h0, 0, 1, 0);
    chk({macc, oacc}, 32'h1);
    pins(3'h0, 1, 0, 0);
    chk({macc, oacc}, 32'h3);
    pins(3'h0, 0, 0, 0);
    wr(LSL_ADDR_CODE, 32'h1111);
    rd(LSL_ADDR_CODE, 32'h0);
    chk(oacc, 32'h0);
    wr(LSL_ADDR_CODE, 32'h1234);
    rd(LSL_ADDR_CODE, 32'h1);
    chk(oacc, 32'h1);
    wr(LSL_ADDR_STATUS, 32'hffffffff);
    rd(LSL_ADDR_STATUS, 32'h408);
    wr(LSL_ADDR_LOW, 32'd100);
    wr(LSL_ADDR_HIGH, 32'd200);
    wr(LSL_ADDR_OUTCFG, 32'ha5);
    for (int k = 0; k < 8; k++) begin
      rng = xs(rng);
      case (k)
        0: s = 32'd99;
        1: s = 32'd100;
        2: s = 32'd200;
        3: s = 32'd201;
        default: s = k[0] ? 32'd201 + rng % 500 : 32'd100 + rng % 101;
      endcase
      e = (s >= 100 && s <= 200);
      wr(LSL_ADDR_SPEED, s);
      tick(2);
      #1;
      chk(motion, e);
      chk(mout, e ? 32'ha5 : 32'h0);
    end
    bus(1'b1, LSL_ADDR_OUTCFG, 32'hff5a00, 4'h2);
    rd(LSL_ADDR_OUTCFG, 32'h5aa5);
    stepn(5);
    chk(pos, 32'h5);
    pins(3'h0, 0, 0, 1);
    chk(pos, 32'h0);
    stepn(3);
    chk(pos, 32'h3);
    pins(3'h0, 0, 0, 0);
    rd(LSL_ADDR_POS, 32'h3);
    @(posedge clk_i);
    rezero_on <= 1;
    tick(4);
    rezero_on <= 0;
    tick(16);
    #1;
    chk(pos, 32'h3);
    wr(LSL_ADDR_CTRL, 32'h08);
    @(posedge clk_i);
    grouped <= 1;
    pins(3'h0, 0, 0, 1);
    chk({g1, pos}, 32'h10003);
    pins(3'h0, 0, 0, 0);
    chk(g1, 32'h0);
    wr(LSL_ADDR_CTRL, 32'h10);
    tick(2);
    #1;
    chk(g1, 32'h0);
    pins(3'h0, 0, 0, 1);
    pins(3'h0, 0, 0, 0);
    chk({g1, pos}, 32'h10003);
    wr(LSL_ADDR_CTRL, 32'h18);
    tick(2);
    #1;
    chk(g1, 32'h0);
    wr(LSL_ADDR_CTRL, 32'h00);
    tick(2);
    #1;
    chk(g1, 32'h1);
    rd(8'h40, LSL_UNMAPPED);
    wr(LSL_ADDR_OFFSET, 32'h30);
    @(posedge clk_i);
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    tick(1);
    #1;
    chk(pos, 32'h0);
    tick(2);
    summarize;
  end
endmodule : tb_lsl_logic_inputs
`default_nettype wire
